/* slt_tuning_regs.sv */
// lane tuning registers behind a clause-45 style management serial port
// assumes mdc and mdio are synchronous to sys_clk_i and mdc is at most a quarter of its rate
//
// What this block does
// - receiver tuning register at offset 0x0004, device 0x1E, resets to 0x1500.
// - bit 15 forces receive adc track mode; zero after reset.
// - bits 14:12 pick precursor equaliser strength in odd ninths; resets to 001.
// - bits 11:10 pick recovery loop order; 11 reserved; resets to 01.
// - bits 9:8 pick 4, 8, 16 or 32 votes; resets to eight.
// - bit 6 turns off receive high frequency peaking; zero after reset.
// - bit 5 enables short channel clock recovery; zero after reset.
// - bits 4:0 hold cursor reduction code, reserved codes kept; resets to zero.
// - transmit tap register at offset 0x0005, device 0x1E, resets to 0x2000.
// - polarity bits 15/14, reserved 13, post one 12:8, pre 7:4, post two 3:0.
// - swing code maps monotonically to sixteen output amplitudes, 0000 smallest.
// - each polarity bit swaps its pair's positive pin; clear keeps normal polarity.
`timescale 1ns/1ns
`include "slt_defines.svh"
module slt_tuning_regs (
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic [4:0] phy_addr_i,
	input wire logic mdc_i,
	input wire logic mdio_i,
	output logic mdio_o,
	output logic mdio_oe_o,
	output logic adc_track_force_o,
	output logic [2:0] rx_precursor_eq_sel_o,
	output logic [1:0] recovery_loop_order_o,
	output logic [1:0] recovery_vote_threshold_o,
	output logic [5:0] recovery_vote_count_o,
	output logic rx_peaking_off_o,
	output logic short_channel_recovery_o,
	output logic [4:0] cursor_reduction_code_o,
	output logic rx_polarity_invert_o,
	output logic tx_polarity_invert_o,
	output logic [4:0] post_tap_one_weight_o,
	output logic [3:0] pre_tap_weight_o,
	output logic [3:0] post_tap_two_weight_o,
	input wire logic [3:0] tx_swing_code_i,
	output logic [10:0] tx_swing_mv_o
);
	import slt_pkg::*;

	slt_state_t state_q;
	slt_op_t op_q;
	logic mdc_prev_q;
	logic [5:0] pre_cnt_q;
	logic [4:0] bit_cnt_q;
	logic [13:0] hdr_q;
	logic hit_q;
	logic [15:0] addr_q;
	logic [15:0] shift_q;
	logic rise;
	logic [13:0] frame_bits;
	logic hdr_hit;
	logic ta_rise;
	logic ta_end;
	logic data_rise;
	logic data_end;
	logic is_read;
	logic [15:0] wdata;
	logic [15:0] rd_value;
	logic commit_wr;

	slt_reg_if tune_if ();
	slt_reg_if taps_if ();

	// ==========================================================
	// register storage
	// tuning reset value
	slt_reg16 #(.RESET_VAL(`SLT_RST_RX_TUNE)) u_rx_tune (
		.sys_clk_i(sys_clk_i),
		.rst_n_i(rst_n_i),
		.bus(tune_if.owner)
	);

	slt_reg16 #(.RESET_VAL(`SLT_RST_TX_TAPS)) u_tx_taps (
		.sys_clk_i(sys_clk_i),
		.rst_n_i(rst_n_i),
		.bus(taps_if.owner)
	);

	// ==========================================================
	// frame decode
	// a single flop suffices for edge detection since mdc is synchronous
	// resets high so an mdc left high across reset is not taken as a fresh bit
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mdc_prev_q <= 1'b1;
		end else begin
			mdc_prev_q <= mdc_i;
		end
	end

	assign rise = mdc_i & ~mdc_prev_q;
	assign frame_bits = {hdr_q[12:0], mdio_i};
	assign hdr_hit = (frame_bits[13:12] == 2'h0) && (frame_bits[9:5] == phy_addr_i) &&
		(frame_bits[4:0] == `SLT_DEVAD);
	assign ta_rise = rise && (state_q == SLT_TA);
	assign ta_end = ta_rise && (bit_cnt_q == 5'h01);
	assign data_rise = rise && (state_q == SLT_DATA);
	assign data_end = data_rise && (bit_cnt_q == `SLT_DATA_LAST);
	assign is_read = op_q[1];
	assign wdata = {shift_q[14:0], mdio_i};
	assign commit_wr = data_end && hit_q && (op_q == SLT_OP_WRITE);

	always_comb begin
		if (addr_q == `SLT_OFS_RX_TUNE) begin
			rd_value = tune_if.value;
		end else if (addr_q == `SLT_OFS_TX_TAPS) begin
			rd_value = taps_if.value;
		end else begin
			rd_value = 16'h0000;
		end
	end

	// frames for other ports or devices are walked through but never acted on
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_q <= SLT_PRE;
			op_q <= SLT_OP_ADDR;
			pre_cnt_q <= 6'h00;
			bit_cnt_q <= 5'h00;
			hdr_q <= 14'h0000;
			hit_q <= 1'b0;
			shift_q <= 16'h0000;
		end else if (rise) begin
			case (state_q)
				SLT_PRE: begin
					if (mdio_i) begin
						if (pre_cnt_q != `SLT_PREAMBLE_BITS) begin
							pre_cnt_q <= pre_cnt_q + 6'h01;
						end
					end else if (pre_cnt_q == `SLT_PREAMBLE_BITS) begin
						state_q <= SLT_HDR;
						bit_cnt_q <= 5'h01;
						hdr_q <= 14'h0000;
						pre_cnt_q <= 6'h00;
					end else begin
						pre_cnt_q <= 6'h00;
					end
				end
				SLT_HDR: begin
					hdr_q <= frame_bits;
					bit_cnt_q <= bit_cnt_q + 5'h01;
					if (bit_cnt_q == `SLT_HDR_LAST) begin
						state_q <= SLT_TA;
						bit_cnt_q <= 5'h00;
						op_q <= slt_op_t'(frame_bits[11:10]);
						hit_q <= hdr_hit;
					end
				end
				SLT_TA: begin
					bit_cnt_q <= bit_cnt_q + 5'h01;
					if (bit_cnt_q == 5'h01) begin
						state_q <= SLT_DATA;
						bit_cnt_q <= 5'h00;
						shift_q <= (hit_q && is_read) ? rd_value : 16'h0000;
					end
				end
				SLT_DATA: begin
					bit_cnt_q <= bit_cnt_q + 5'h01;
					shift_q <= is_read ? {shift_q[14:0], 1'b0} : wdata;
					if (bit_cnt_q == `SLT_DATA_LAST) begin
						state_q <= SLT_PRE;
						pre_cnt_q <= 6'h00;
					end
				end
				default: begin
					state_q <= SLT_PRE;
				end
			endcase
		end
	end

	// ==========================================================
	// address pointer
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			addr_q <= 16'h0000;
		end else if (data_end && hit_q && (op_q == SLT_OP_ADDR)) begin
			addr_q <= wdata;
		end else if (data_end && hit_q && (op_q == SLT_OP_RDINC)) begin
			addr_q <= addr_q + 16'h0001;
		end
	end

	assign tune_if.wr_en = commit_wr && (addr_q == `SLT_OFS_RX_TUNE);
	assign tune_if.wr_data = wdata;
	assign taps_if.wr_en = commit_wr && (addr_q == `SLT_OFS_TX_TAPS);
	assign taps_if.wr_data = wdata;

	// ==========================================================
	// serial data out
	// second turnaround bit is driven low, data follows msb first
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mdio_o <= 1'b0;
			mdio_oe_o <= 1'b0;
		end else if (ta_rise && (bit_cnt_q == 5'h00) && hit_q && is_read) begin
			mdio_o <= 1'b0;
			mdio_oe_o <= 1'b1;
		end else if (ta_end && mdio_oe_o) begin
			mdio_o <= rd_value[15];
		end else if (data_end) begin
			mdio_o <= 1'b0;
			mdio_oe_o <= 1'b0;
		end else if (data_rise && mdio_oe_o) begin
			mdio_o <= shift_q[14];
		end
	end

	// ==========================================================
	// field outputs
	// adc track
	assign adc_track_force_o = tune_if.value[`SLT_ADC_TRACK];
	assign rx_precursor_eq_sel_o = tune_if.value[`SLT_EQ_HI:`SLT_EQ_LO];
	// loop order, reserved code passed unchanged
	assign recovery_loop_order_o = tune_if.value[`SLT_ORDER_HI:`SLT_ORDER_LO];
	assign recovery_vote_threshold_o = tune_if.value[`SLT_VOTE_HI:`SLT_VOTE_LO];
	assign recovery_vote_count_o = 6'h04 << recovery_vote_threshold_o;
	assign rx_peaking_off_o = tune_if.value[`SLT_PEAK_OFF];
	assign short_channel_recovery_o = tune_if.value[`SLT_SHORT_CH];
	assign cursor_reduction_code_o = tune_if.value[`SLT_CRF_HI:`SLT_CRF_LO];
	assign rx_polarity_invert_o = taps_if.value[`SLT_RX_INV];
	assign tx_polarity_invert_o = taps_if.value[`SLT_TX_INV];
	assign post_tap_one_weight_o = taps_if.value[`SLT_POST1_HI:`SLT_POST1_LO];
	assign pre_tap_weight_o = taps_if.value[`SLT_PRE_HI:`SLT_PRE_LO];
	assign post_tap_two_weight_o = taps_if.value[`SLT_POST2_HI:`SLT_POST2_LO];

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tx_swing_mv_o <= 11'h000;
		end else begin
			case (tx_swing_code_i)
				4'h0: tx_swing_mv_o <= 11'h082;
				4'h1: tx_swing_mv_o <= 11'h0dc;
				4'h2: tx_swing_mv_o <= 11'h12c;
				4'h3: tx_swing_mv_o <= 11'h186;
				4'h4: tx_swing_mv_o <= 11'h1e0;
				4'h5: tx_swing_mv_o <= 11'h23a;
				4'h6: tx_swing_mv_o <= 11'h294;
				4'h7: tx_swing_mv_o <= 11'h2ee;
				4'h8: tx_swing_mv_o <= 11'h33e;
				4'h9: tx_swing_mv_o <= 11'h3a2;
				4'ha: tx_swing_mv_o <= 11'h3fc;
				4'hb: tx_swing_mv_o <= 11'h456;
				4'hc: tx_swing_mv_o <= 11'h49c;
				4'hd: tx_swing_mv_o <= 11'h4f6;
				4'he: tx_swing_mv_o <= 11'h53c;
				default: tx_swing_mv_o <= 11'h578;
			endcase
		end
	end

	// ==========================================================
	// checks
	logic tune_written_q;
	logic taps_written_q;

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tune_written_q <= 1'b0;
			taps_written_q <= 1'b0;
		end else begin
			tune_written_q <= tune_written_q | tune_if.wr_en;
			taps_written_q <= taps_written_q | taps_if.wr_en;
		end
	end

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);

	sequence s_tune_wr;
		tune_if.wr_en;
	endsequence

	sequence s_taps_wr;
		taps_if.wr_en;
	endsequence

	sequence s_read_ta;
		ta_rise && (bit_cnt_q == 5'h00) && hit_q && is_read;
	endsequence

	property p_tune_reset;
		!tune_written_q |-> (tune_if.value == 16'h1500);
	endproperty
	a_tune_reset: assert property (p_tune_reset) else $error("tuning reset value lost");

	property p_track_hold;
		!tune_if.wr_en |=> $stable(adc_track_force_o);
	endproperty
	a_track_hold: assert property (p_track_hold) else $error("track bit moved without write");

	property p_eq_write;
		s_tune_wr |=> (rx_precursor_eq_sel_o == $past(wdata[14:12]));
	endproperty
	a_eq_write: assert property (p_eq_write) else $error("equaliser field not updated");

	property p_order_write;
		s_tune_wr |=> (recovery_loop_order_o == $past(wdata[11:10]));
	endproperty
	a_order_write: assert property (p_order_write) else $error("loop order not updated");

	property p_vote_count;
		(recovery_vote_count_o == ((recovery_vote_threshold_o == 2'h0) ? 6'h04 :
			(recovery_vote_threshold_o == 2'h1) ? 6'h08 :
			(recovery_vote_threshold_o == 2'h2) ? 6'h10 : 6'h20));
	endproperty
	a_vote_count: assert property (p_vote_count) else $error("vote count wrong");

	property p_low_bits_write;
		s_tune_wr |=> ({rx_peaking_off_o, short_channel_recovery_o, cursor_reduction_code_o}
			== $past(wdata[6:0]));
	endproperty
	a_low_bits_write: assert property (p_low_bits_write) else $error("low tuning bits wrong");

	property p_short_hold;
		!tune_if.wr_en |=> $stable(short_channel_recovery_o);
	endproperty
	a_short_hold: assert property (p_short_hold) else $error("short channel bit moved");

	property p_crf_hold;
		!tune_if.wr_en |=> $stable(cursor_reduction_code_o);
	endproperty
	a_crf_hold: assert property (p_crf_hold) else $error("cursor reduction moved");

	property p_taps_reset;
		!taps_written_q |-> (taps_if.value == 16'h2000);
	endproperty
	a_taps_reset: assert property (p_taps_reset) else $error("taps reset value lost");

	property p_taps_write;
		s_taps_wr |=> ({post_tap_one_weight_o, pre_tap_weight_o, post_tap_two_weight_o}
			== $past(wdata[12:0]));
	endproperty
	a_taps_write: assert property (p_taps_write) else $error("tap weights not updated");

	property p_swing_rise;
		(tx_swing_code_i > $past(tx_swing_code_i)) |=> (tx_swing_mv_o > $past(tx_swing_mv_o));
	endproperty
	a_swing_rise: assert property (p_swing_rise) else $error("swing not monotonic");

	property p_pol_write;
		s_taps_wr |=> ({rx_polarity_invert_o, tx_polarity_invert_o} == $past(wdata[15:14]));
	endproperty
	a_pol_write: assert property (p_pol_write) else $error("polarity bits not updated");

	property p_read_drive;
		s_read_ta |=> mdio_oe_o && !mdio_o;
	endproperty
	a_read_drive: assert property (p_read_drive) else $error("turnaround not driven low");

	property p_read_load;
		ta_end && hit_q && is_read |=> (shift_q == $past(rd_value)) && (mdio_o == shift_q[15]);
	endproperty
	a_read_load: assert property (p_read_load) else $error("read data not loaded");
endmodule : slt_tuning_regs

/* slt_defines.svh */
// offsets, field positions, reset values and frame counts of the lane tuning registers
// assumes inclusion by bare name from the design module and the bench
`ifndef SLT_DEFINES_SVH
`define SLT_DEFINES_SVH

// ==========================================================
// management addressing
`define SLT_DEVAD 5'h1e
`define SLT_OFS_RX_TUNE 16'h0004
`define SLT_OFS_TX_TAPS 16'h0005
`define SLT_PREAMBLE_BITS 6'h20
`define SLT_HDR_LAST 5'h0d
`define SLT_DATA_LAST 5'h0f

// ==========================================================
// reset values
`define SLT_RST_RX_TUNE 16'h1500
`define SLT_RST_TX_TAPS 16'h2000

// ==========================================================
// receiver tuning fields
`define SLT_ADC_TRACK 15
`define SLT_EQ_HI 14
`define SLT_EQ_LO 12
`define SLT_ORDER_HI 11
`define SLT_ORDER_LO 10
`define SLT_VOTE_HI 9
`define SLT_VOTE_LO 8
`define SLT_PEAK_OFF 6
`define SLT_SHORT_CH 5
`define SLT_CRF_HI 4
`define SLT_CRF_LO 0

// ==========================================================
// transmit tap fields
`define SLT_RX_INV 15
`define SLT_TX_INV 14
`define SLT_POST1_HI 12
`define SLT_POST1_LO 8
`define SLT_PRE_HI 7
`define SLT_PRE_LO 4
`define SLT_POST2_HI 3
`define SLT_POST2_LO 0

`endif

/* slt_pkg.sv */
// types shared by the lane tuning register modules
// assumes nothing beyond the defines header
package slt_pkg;
	typedef enum logic [1:0] {
		SLT_OP_ADDR = 2'h0,
		SLT_OP_WRITE = 2'h1,
		SLT_OP_RDINC = 2'h2,
		SLT_OP_READ = 2'h3
	} slt_op_t;

	typedef enum logic [1:0] {
		SLT_PRE,
		SLT_HDR,
		SLT_TA,
		SLT_DATA
	} slt_state_t;
endpackage : slt_pkg

/* slt_reg_if.sv */
// write strobe, write data and held value of one 16-bit register
// assumes a single clock shared by both ends
`timescale 1ns/1ns
interface slt_reg_if;
	logic wr_en;
	logic [15:0] wr_data;
	logic [15:0] value;

	modport owner (input wr_en, input wr_data, output value);
	modport ctrl (output wr_en, output wr_data, input value);
endinterface : slt_reg_if

/* slt_reg16.sv */
// one read/write 16-bit register with a parameterised reset value
// assumes a synchronous write strobe from the management frame logic
`timescale 1ns/1ns
module slt_reg16 #(
	parameter logic [15:0] RESET_VAL = 16'h0000
) (
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	slt_reg_if.owner bus
);
	logic [15:0] value_q;

	// every bit, reserved ones too, is stored as written
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			value_q <= RESET_VAL;
		end else if (bus.wr_en) begin
			value_q <= bus.wr_data;
		end
	end

	assign bus.value = value_q;
endmodule : slt_reg16

/* tb_top.sv */
// self-checking bench for the lane tuning register block
// assumes the design package and defines header are compiled first; host drives mdc/mdio
`timescale 1ns/1ns
`include "slt_defines.svh"
module tb_top;
	import slt_pkg::*;
	localparam logic [4:0] PA = 5'h0b;
	localparam logic [15:0] RX = `SLT_OFS_RX_TUNE;
	localparam logic [15:0] TX = `SLT_OFS_TX_TAPS;
	logic sys_clk_i, rst_n_i, mdc_i, mdio_i, host_en, host_val;
	logic [4:0] phy_addr_i;
	logic mdio_o, mdio_oe_o, adc_o, peak_o, short_o, rxinv_o, txinv_o;
	logic [2:0] eq_o;
	logic [1:0] order_o, thr_o;
	logic [5:0] votes_o;
	logic [4:0] crf_o, post1_o;
	logic [3:0] pre_o, post2_o, tx_swing_code_i;
	logic [10:0] swing_mv_o;
	int n_mismatch = 0;
	int total_checks = 0;

	// wire level: pulled up when nobody drives
	assign mdio_i = mdio_oe_o ? mdio_o : (host_en ? host_val : 1'b1);

	slt_tuning_regs DUT (
		.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .phy_addr_i(phy_addr_i),
		.mdc_i(mdc_i), .mdio_i(mdio_i), .mdio_o(mdio_o), .mdio_oe_o(mdio_oe_o),
		.adc_track_force_o(adc_o), .rx_precursor_eq_sel_o(eq_o),
		.recovery_loop_order_o(order_o), .recovery_vote_threshold_o(thr_o),
		.recovery_vote_count_o(votes_o), .rx_peaking_off_o(peak_o),
		.short_channel_recovery_o(short_o), .cursor_reduction_code_o(crf_o),
		.rx_polarity_invert_o(rxinv_o), .tx_polarity_invert_o(txinv_o),
		.post_tap_one_weight_o(post1_o), .pre_tap_weight_o(pre_o),
		.post_tap_two_weight_o(post2_o), .tx_swing_code_i(tx_swing_code_i),
		.tx_swing_mv_o(swing_mv_o)
	);

	// ==========================================================
	// reporting
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t ns: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chk

	task automatic stop_test();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : stop_test

	// ==========================================================
	// management link
	// mdc held two sys cycles per phase, the minimum the port samples reliably
	task automatic bit_io(input logic en, input logic b, output logic s);
		@(negedge sys_clk_i);
		host_en = en;
		host_val = b;
		mdc_i = 1'b0;
		repeat (2) @(negedge sys_clk_i);
		s = mdio_i;
		if (en && mdio_oe_o !== 1'b0) begin
			chk(16'(mdio_oe_o), 16'h0, "device drives against host");
		end
		mdc_i = 1'b1;
		@(negedge sys_clk_i);
	endtask : bit_io

	task automatic frame(input slt_op_t op, input logic [4:0] pa, input logic [4:0] dv,
			input logic [15:0] d, output logic [15:0] r, output logic ta);
		logic [63:0] bits;
		logic s;
		bits = {32'hffffffff, 2'b00, op, pa, dv, 2'b10, d};
		for (int i = 63; i >= 0; i--) begin
			bit_io(!(op[1] && i < 18), bits[i], s);
			if (i == 16) begin
				ta = s;
			end
			if (i < 16) begin
				r[i] = s;
			end
		end
		host_en = 1'b0;
	endtask : frame

	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		logic [15:0] r;
		logic t;
		frame(SLT_OP_ADDR, PA, `SLT_DEVAD, a, r, t);
		frame(SLT_OP_WRITE, PA, `SLT_DEVAD, d, r, t);
	endtask : wr

	task automatic rd(input logic [15:0] a, input logic [15:0] e);
		logic [15:0] r;
		logic t;
		frame(SLT_OP_ADDR, PA, `SLT_DEVAD, a, r, t);
		frame(SLT_OP_READ, PA, `SLT_DEVAD, 16'h0, r, t);
		chk(16'(t), 16'h0, "turnaround not driven low");
		chk(r, e, "read data");
	endtask : rd

	// field ports against a register word; bits without a port are masked out
	task automatic chk_rx(input logic [15:0] w);
		chk({adc_o, eq_o, order_o, thr_o, 1'b0, peak_o, short_o, crf_o}, w & 16'hff7f, "rx fields");
		chk(16'(votes_o), 16'(6'd4 << w[9:8]), "vote count");
	endtask : chk_rx

	task automatic chk_tx(input logic [15:0] w);
		chk({rxinv_o, txinv_o, 1'b0, post1_o, pre_o, post2_o}, w & 16'hdfff, "tx fields");
	endtask : chk_tx

	// ==========================================================
	// scenarios
	task automatic t_defaults();
		chk_rx(16'h1500);
		chk_tx(16'h2000);
		rd(RX, 16'h1500);
		rd(TX, 16'h2000);
	endtask : t_defaults

	task automatic t_rx_fields();
		logic [15:0] pat [4] = '{16'hffff, 16'h2a4b, 16'h80b1, 16'h4c27};
		for (int i = 0; i < 4; i++) begin
			wr(RX, pat[i]);
			chk_rx(pat[i]);
			rd(RX, pat[i]);
		end
	endtask : t_rx_fields

	task automatic t_tx_fields();
		logic [15:0] pat [4] = '{16'hffff, 16'h5a5a, 16'ha5a5, 16'h0000};
		for (int i = 0; i < 4; i++) begin
			wr(TX, pat[i]);
			chk_tx(pat[i]);
			rd(TX, pat[i]);
		end
	endtask : t_tx_fields

	// read-increment moves the pointer, plain read leaves it
	task automatic t_pointer();
		logic [15:0] r;
		logic t;
		wr(RX, 16'h1234);
		wr(TX, 16'h8765);
		frame(SLT_OP_ADDR, PA, `SLT_DEVAD, RX, r, t);
		frame(SLT_OP_RDINC, PA, `SLT_DEVAD, 16'h0, r, t);
		chk(r, 16'h1234, "read-increment first word");
		frame(SLT_OP_READ, PA, `SLT_DEVAD, 16'h0, r, t);
		chk(r, 16'h8765, "pointer after increment");
		frame(SLT_OP_READ, PA, `SLT_DEVAD, 16'h0, r, t);
		chk(r, 16'h8765, "plain read keeps pointer");
	endtask : t_pointer

	// frames for another port or device, and unmapped offsets, change nothing
	task automatic t_refused();
		logic [15:0] r;
		logic t;
		wr(16'h0006, 16'hbeef);
		rd(16'h0006, 16'h0000);
		frame(SLT_OP_ADDR, PA, `SLT_DEVAD, RX, r, t);
		frame(SLT_OP_WRITE, PA ^ 5'h01, `SLT_DEVAD, 16'hffff, r, t);
		frame(SLT_OP_WRITE, PA, 5'h1d, 16'hffff, r, t);
		chk_rx(16'h1234);
		frame(SLT_OP_READ, PA, 5'h1d, 16'h0, r, t);
		chk(r, 16'hffff, "foreign device read left undriven");
		rd(TX, 16'h8765);
	endtask : t_refused

	task automatic t_swing();
		logic [10:0] mv [16] = '{11'd130, 11'd220, 11'd300, 11'd390, 11'd480, 11'd570,
			11'd660, 11'd750, 11'd830, 11'd930, 11'd1020, 11'd1110, 11'd1180, 11'd1270,
			11'd1340, 11'd1400};
		for (int i = 0; i < 16; i++) begin
			@(negedge sys_clk_i);
			tx_swing_code_i = 4'(i);
			@(negedge sys_clk_i);
			chk(16'(swing_mv_o), 16'(mv[i]), "swing amplitude");
		end
	endtask : t_swing

	task automatic t_reset_mid();
		@(negedge sys_clk_i);
		rst_n_i = 1'b0;
		repeat (2) @(negedge sys_clk_i);
		chk_rx(16'h1500);
		chk_tx(16'h2000);
		rst_n_i = 1'b1;
		rd(RX, 16'h1500);
		rd(TX, 16'h2000);
	endtask : t_reset_mid

	// ==========================================================
	// clock, sequence and watchdog
	initial begin
		sys_clk_i = 1'b0;
		forever begin
			#50 sys_clk_i = ~sys_clk_i;
		end
	end

	initial begin
		rst_n_i = 1'b0;
		mdc_i = 1'b0;
		host_en = 1'b0;
		host_val = 1'b1;
		phy_addr_i = PA;
		tx_swing_code_i = 4'h0;
		repeat (3) @(negedge sys_clk_i);
		rst_n_i = 1'b1;
		t_defaults();
		t_rx_fields();
		t_tx_fields();
		t_pointer();
		t_refused();
		t_swing();
		t_reset_mid();
		stop_test();
	end

	// 58 frames of 256 cycles are expected; allow several times that
	initial begin
		#5000000;
		n_mismatch++;
		$display("[FAIL] %0t ns: run did not finish in time", $time);
		stop_test();
	end
endmodule : tb_top
